/* logic/adc_ctl_pkg.sv */
// Register map, field layout and timing constants of the converter control block.
`default_nettype none
package adc_ctl_pkg;

	// Register offsets (byte addresses).
	localparam logic [6:0] OFF_VERSION_IDENT   = 7'h00;
	localparam logic [6:0] OFF_CONVERTER_CONFIG = 7'h04;
	localparam logic [6:0] OFF_CONVERTER_CONTROL = 7'h08;
	localparam logic [6:0] OFF_CLOCK_OUTPUT_CONTROL = 7'h0c;
	localparam logic [6:0] OFF_AMPLIFIER_CONFIG = 7'h10;
	localparam logic [6:0] OFF_INPUT_SWITCH_SELECT = 7'h14;
	localparam logic [6:0] OFF_DECIMATOR_CONFIG = 7'h18;
	localparam logic [6:0] OFF_DOWNSAMPLER_CONFIG = 7'h1c;
	localparam logic [6:0] OFF_SEQUENCE_SLOTS_LOW = 7'h20;
	localparam logic [6:0] OFF_SEQUENCE_SLOTS_HIGH = 7'h24;
	localparam logic [6:0] OFF_CALIBRATION_SET_ONE = 7'h28;
	localparam logic [6:0] OFF_CALIBRATION_SET_TWO = 7'h2c;
	localparam logic [6:0] OFF_CALIBRATION_SET_THREE = 7'h30;
	localparam logic [6:0] OFF_CALIBRATION_SET_FOUR = 7'h34;
	localparam logic [6:0] OFF_CALIBRATION_SELECTOR = 7'h38;
	localparam logic [6:0] OFF_GUARD_THRESHOLDS = 7'h3c;
	localparam logic [6:0] OFF_GUARD_CHANNEL_SELECT = 7'h40;
	localparam logic [6:0] OFF_DOWNSAMPLER_RESULT = 7'h44;
	localparam logic [6:0] OFF_DECIMATOR_RESULT = 7'h48;
	localparam logic [6:0] OFF_INTERRUPT_FLAGS = 7'h4c;
	localparam logic [6:0] OFF_INTERRUPT_MASK = 7'h50;
	localparam logic [6:0] OFF_STARTUP_DELAY_TIMERS = 7'h54;
	localparam int         NUM_REGS = 22;

	// Arbitrary identification value.
	localparam logic [31:0] VERSION_IDENT_VALUE = 32'h0000_0001;

	// Interrupt bit positions.
	localparam int BIT_FILTER_SATURATION = 7;
	localparam int BIT_FILTER_OVERRUN = 6;
	localparam int BIT_DOWNSAMPLER_OVERRUN = 5;
	localparam int BIT_GUARD_EVENT = 4;
	localparam int BIT_SEQUENCE_DONE = 3;
	localparam int BIT_FILTER_DONE = 2;
	localparam int BIT_DOWNSAMPLER_DONE = 1;
	localparam logic [7:0] IRQ_IMPL_MASK = 8'hfe;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

	// Timer configuration fields.
	localparam int TMR_STEP_SEL_BIT = 16;
	localparam int TMR_BIAS_LSB = 8;
	localparam int TMR_SETTLE_LSB = 0;
	localparam logic [16:0] STARTUP_DELAY_TIMERS_RESET = 17'h09628;
	localparam logic [16:0] STARTUP_DELAY_TIMERS_IMPL_MASK = 17'h1ffff;
	localparam logic [6:0]  OFF_REGULATOR_CTRL_BIT = 7'h10;

	// Timing: the step clock is 32 MHz; the short step is 128 of its cycles (4 us).
	localparam int  STEP_CLOCK_KHZ = 32000;
	localparam int  STEP_CLOCK_CYCLES = 128;
	localparam int  LONG_STEP_MULT = 1024;
	localparam int  MCLK_KHZ = 10000;
	localparam int  SHORT_STEP_NS = (STEP_CLOCK_CYCLES * 1000000) / STEP_CLOCK_KHZ;
	localparam int  SHORT_STEP_CYCLES = (SHORT_STEP_NS * MCLK_KHZ) / 1000000;

endpackage : adc_ctl_pkg
`default_nettype wire

/* logic/step_delay_timer.sv */
// Down-counting delay timer measured in whole steps of a programmable length.
`timescale 1ns/10ps
`default_nettype none
module step_delay_timer #(
	parameter int STEP_W = 16
) (
	// Clock and reset.
	input  wire logic              mclk,
	input  wire logic              reset,
	// Control.
	input  wire logic              start,
	input  wire logic              abort,
	input  wire logic [STEP_W-1:0] step_cycles,
	input  wire logic [7:0]        steps,
	// Status.
	output logic                   busy
);
	typedef struct packed {
		logic              busy;
		logic [7:0]        steps_left;
		logic [STEP_W-1:0] cyc;
	} tmr_s;

	tmr_s st_r;
	tmr_s st_nxt;

	// The step length is sampled every step so a change applies from the next step on.
	always_comb begin
		st_nxt = st_r;
		if (abort) begin
			st_nxt.busy = 1'b0;
		end else if (start) begin
			st_nxt.busy = (steps != 8'h00);
			st_nxt.steps_left = steps;
			st_nxt.cyc = step_cycles - STEP_W'(1);
		end else if (st_r.busy) begin
			if (st_r.cyc != '0) begin
				st_nxt.cyc = st_r.cyc - STEP_W'(1);
			end else if (st_r.steps_left == 8'h01) begin
				st_nxt.busy = 1'b0;
				st_nxt.steps_left = 8'h00;
			end else begin
				st_nxt.steps_left = st_r.steps_left - 8'h01;
				st_nxt.cyc = step_cycles - STEP_W'(1);
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.busy;
endmodule : step_delay_timer
`default_nettype wire

/* logic/adc_irq_timers.sv */
// Converter interrupt flags, mask and start-up delay timers behind an Avalon-MM slave.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE1] Mask bit 7 gates the filter-saturation interrupt.
// [RULE2] Mask bit 6 gates the filter-overrun interrupt.
// [RULE3] Mask bit 5 gates the down-sampler overrun interrupt.
// [RULE4] Mask bit 4 gates the guard (watchdog) interrupt.
// [RULE5] Mask bit 3 gates the sequence-done interrupt.
// [RULE6] Mask bit 2 gates the filter-done interrupt.
// [RULE7] Mask bit 1 gates the down-sampler-done interrupt.
// [RULE8] Software writes mask bits 31 to 8 as zero.
// [RULE9] Timer bit 16 picks a 4 us or 4.096 ms precharge step.
// [RULE10] Short step is 128 cycles at 32 MHz; long step is 1024 times that.
// [RULE11] Precharge pulse starts at amplifier enable rise, lasts field bits 15:8 steps.
// [RULE12] Precharge field resets to 150; 255 is the largest count.
// [RULE13] Regulator settle wait of bits 7:0 times 4 us precedes converter on.
// [RULE14] Regulator settle field resets to 40.
// [RULE15] Software keeps timer bits 31 to 17 at zero.
// [RULE16] Status flags set by events, cleared only by writing one.
// [RULE17] Interrupt output is high while any enabled flag is set.
module adc_irq_timers #(
	parameter int SHORT_STEP = adc_ctl_pkg::SHORT_STEP_CYCLES,
	parameter int LONG_STEP  = adc_ctl_pkg::SHORT_STEP_CYCLES * adc_ctl_pkg::LONG_STEP_MULT
) (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        reset,
	// Avalon-MM slave.
	input  wire logic [6:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Event pulses from the conversion datapath (same clock).
	input  wire logic [7:0]  event_pulse,
	// Power sequencing pins.
	input  wire logic        amplifier_enable_signal,
	input  wire logic        converter_regulator,
	output logic             bias_precharge,
	output logic             converter_on,
	// Interrupt.
	output logic             irq
);
	localparam int STEP_W = 24;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [7:0]  flags;
		logic [7:0]  mask;
		logic [16:0] tconf;
		logic        irq;
		logic        amp_s1;
		logic        amp_s2;
		logic        amp_prev;
		logic        reg_s1;
		logic        reg_s2;
		logic        reg_prev;
		logic        prech;
		logic        conv_on;
	} ctl_s;

	ctl_s st_r;
	ctl_s st_nxt;

	logic             prech_busy;
	logic             settle_busy;
	logic             amp_rise;
	logic             reg_rise;
	logic [STEP_W-1:0] prech_step;

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	assign amp_rise = st_r.amp_s2 && !st_r.amp_prev; // [RULE11]
	assign reg_rise = st_r.reg_s2 && !st_r.reg_prev; // [RULE13]

	// The long step is a multiple of the short one, so both come from the same counter.
	assign prech_step = st_r.tconf[adc_ctl_pkg::TMR_STEP_SEL_BIT] ?
	                    STEP_W'(LONG_STEP) : STEP_W'(SHORT_STEP); // [RULE9] [RULE10]

	step_delay_timer #(.STEP_W(STEP_W)) u_prech (
		.mclk        (mclk),
		.reset       (reset),
		.start       (amp_rise),
		.abort       (!st_r.amp_s2),
		.step_cycles (prech_step),
		.steps       (st_r.tconf[adc_ctl_pkg::TMR_BIAS_LSB +: 8]),
		.busy        (prech_busy)
	);

	step_delay_timer #(.STEP_W(STEP_W)) u_settle (
		.mclk        (mclk),
		.reset       (reset),
		.start       (reg_rise),
		.abort       (!st_r.reg_s2),
		.step_cycles (STEP_W'(SHORT_STEP)),
		.steps       (st_r.tconf[adc_ctl_pkg::TMR_SETTLE_LSB +: 8]),
		.busy        (settle_busy)
	);

	always_comb begin
		logic [31:0] wm;
		logic [31:0] wd;
		logic [7:0]  clr;
		wm = be_mask(avs_byteenable);
		wd = avs_writedata & wm;
		clr = 8'h00;
		st_nxt = st_r;
		st_nxt.amp_s1 = amplifier_enable_signal;
		st_nxt.amp_s2 = st_r.amp_s1;
		st_nxt.amp_prev = st_r.amp_s2;
		st_nxt.reg_s1 = converter_regulator;
		st_nxt.reg_s2 = st_r.reg_s1;
		st_nxt.reg_prev = st_r.reg_s2;
		// One wait cycle per access: ack rises the cycle after a request and drops after.
		st_nxt.ack = (avs_read || avs_write) && !st_r.ack;
		// A write lands only at the edge where the master sees waitrequest low.
		if (avs_write && st_r.ack) begin
			case (avs_address)
				adc_ctl_pkg::OFF_INTERRUPT_FLAGS: begin
					clr = wd[7:0] & adc_ctl_pkg::IRQ_IMPL_MASK; // [RULE16]
				end
				adc_ctl_pkg::OFF_INTERRUPT_MASK: begin
					st_nxt.mask = ((st_r.mask & ~wm[7:0]) | wd[7:0])
					              & adc_ctl_pkg::IRQ_IMPL_MASK; // [RULE8]
				end
				adc_ctl_pkg::OFF_STARTUP_DELAY_TIMERS: begin
					st_nxt.tconf = ((st_r.tconf & ~wm[16:0]) | wd[16:0])
					               & adc_ctl_pkg::STARTUP_DELAY_TIMERS_IMPL_MASK; // [RULE15]
				end
				default: begin
				end
			endcase
		end
		// A new event in the clearing cycle keeps its flag set.
		st_nxt.flags = ((st_r.flags & ~clr) | event_pulse)
		               & adc_ctl_pkg::IRQ_IMPL_MASK; // [RULE16]
		st_nxt.rdata = 32'h0000_0000;
		if (avs_read && !st_r.ack) begin
			case (avs_address)
				adc_ctl_pkg::OFF_VERSION_IDENT: st_nxt.rdata = adc_ctl_pkg::VERSION_IDENT_VALUE;
				adc_ctl_pkg::OFF_INTERRUPT_FLAGS: st_nxt.rdata = {24'h0, st_r.flags};
				adc_ctl_pkg::OFF_INTERRUPT_MASK: st_nxt.rdata = {24'h0, st_r.mask};
				adc_ctl_pkg::OFF_STARTUP_DELAY_TIMERS: st_nxt.rdata = {15'h0, st_r.tconf};
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		// Each enable bit gates exactly its own flag.
		st_nxt.irq = |(st_r.flags & st_r.mask); // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE17]
		st_nxt.prech = prech_busy; // [RULE11]
		st_nxt.conv_on = st_r.reg_s2 && !settle_busy && !reg_rise; // [RULE13]
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
			st_r.mask <= adc_ctl_pkg::IRQ_MASK_RESET;
			st_r.tconf <= adc_ctl_pkg::STARTUP_DELAY_TIMERS_RESET; // [RULE12] [RULE14]
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata = st_r.rdata;
	assign avs_waitrequest = !st_r.ack;
	assign irq = st_r.irq;
	assign bias_precharge = st_r.prech;
	assign converter_on = st_r.conv_on;

	// Checks.
	property p_irq_follows;
		@(posedge mclk) disable iff (reset)
		1'b1 |=> (irq == $past(|(st_r.flags & st_r.mask)));
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch"); // [RULE17]

	property p_flag_set;
		@(posedge mclk) disable iff (reset)
		event_pulse[adc_ctl_pkg::BIT_GUARD_EVENT] |=> st_r.flags[adc_ctl_pkg::BIT_GUARD_EVENT];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event lost"); // [RULE16]

	property p_flag_sticky;
		@(posedge mclk) disable iff (reset)
		(st_r.flags[adc_ctl_pkg::BIT_SEQUENCE_DONE] && !(avs_write && st_r.ack &&
		 avs_address == adc_ctl_pkg::OFF_INTERRUPT_FLAGS))
		|=> st_r.flags[adc_ctl_pkg::BIT_SEQUENCE_DONE];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // [RULE16]

	property p_masked_quiet;
		@(posedge mclk) disable iff (reset)
		(st_r.mask == 8'h00) |=> !irq;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("irq while masked"); // [RULE1]

	property p_prech_start;
		@(posedge mclk) disable iff (reset)
		(amp_rise && st_r.tconf[15:8] != 8'h00) |=> ##1 bias_precharge;
	endproperty
	a_prech_start: assert property (p_prech_start) else $error("no precharge"); // [RULE11]

	property p_wait_one;
		@(posedge mclk) disable iff (reset)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("no answer");

	property p_settle_hold;
		@(posedge mclk) disable iff (reset)
		reg_rise && st_r.tconf[7:0] != 8'h00 |=> !converter_on [*3];
	endproperty
	a_settle_hold: assert property (p_settle_hold) else $error("converter on early"); // [RULE13]

	property p_reset_tconf;
		@(posedge mclk) disable iff (reset)
		$fell(reset) |-> st_r.tconf == adc_ctl_pkg::STARTUP_DELAY_TIMERS_RESET;
	endproperty
	a_reset_tconf: assert property (p_reset_tconf) else $error("timer reset value"); // [RULE12]

	// Gating, bit by bit: with only one flag set, irq follows that flag's own enable.
	property p_gate_sat;
		@(posedge mclk) disable iff (reset)
		(st_r.flags == (8'h01 << adc_ctl_pkg::BIT_FILTER_SATURATION))
		|=> (irq == $past(st_r.mask[adc_ctl_pkg::BIT_FILTER_SATURATION]));
	endproperty
	a_gate_sat: assert property (p_gate_sat) else $error("saturation gate"); // [RULE1]

	property p_gate_f_ovr;
		@(posedge mclk) disable iff (reset)
		(st_r.flags == (8'h01 << adc_ctl_pkg::BIT_FILTER_OVERRUN))
		|=> (irq == $past(st_r.mask[adc_ctl_pkg::BIT_FILTER_OVERRUN]));
	endproperty
	a_gate_f_ovr: assert property (p_gate_f_ovr) else $error("filter overrun gate"); // [RULE2]

	property p_gate_ds_ovr;
		@(posedge mclk) disable iff (reset)
		(st_r.flags == (8'h01 << adc_ctl_pkg::BIT_DOWNSAMPLER_OVERRUN))
		|=> (irq == $past(st_r.mask[adc_ctl_pkg::BIT_DOWNSAMPLER_OVERRUN]));
	endproperty
	a_gate_ds_ovr: assert property (p_gate_ds_ovr) else $error("sampler overrun gate"); // [RULE3]

	property p_gate_guard;
		@(posedge mclk) disable iff (reset)
		(st_r.flags == (8'h01 << adc_ctl_pkg::BIT_GUARD_EVENT))
		|=> (irq == $past(st_r.mask[adc_ctl_pkg::BIT_GUARD_EVENT]));
	endproperty
	a_gate_guard: assert property (p_gate_guard) else $error("guard gate"); // [RULE4]

	property p_gate_seq;
		@(posedge mclk) disable iff (reset)
		(st_r.flags == (8'h01 << adc_ctl_pkg::BIT_SEQUENCE_DONE))
		|=> (irq == $past(st_r.mask[adc_ctl_pkg::BIT_SEQUENCE_DONE]));
	endproperty
	a_gate_seq: assert property (p_gate_seq) else $error("sequence gate"); // [RULE5]

	property p_gate_f_done;
		@(posedge mclk) disable iff (reset)
		(st_r.flags == (8'h01 << adc_ctl_pkg::BIT_FILTER_DONE))
		|=> (irq == $past(st_r.mask[adc_ctl_pkg::BIT_FILTER_DONE]));
	endproperty
	a_gate_f_done: assert property (p_gate_f_done) else $error("filter done gate"); // [RULE6]

	property p_gate_ds_done;
		@(posedge mclk) disable iff (reset)
		(st_r.flags == (8'h01 << adc_ctl_pkg::BIT_DOWNSAMPLER_DONE))
		|=> (irq == $past(st_r.mask[adc_ctl_pkg::BIT_DOWNSAMPLER_DONE]));
	endproperty
	a_gate_ds_done: assert property (p_gate_ds_done) else $error("sampler done gate"); // [RULE7]

	property p_clear_zero;
		@(posedge mclk) disable iff (reset)
		(avs_write && st_r.ack && avs_address == adc_ctl_pkg::OFF_INTERRUPT_FLAGS &&
		 avs_writedata[7:0] == 8'h00)
		|=> ((st_r.flags & $past(st_r.flags)) == $past(st_r.flags));
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("zero write cleared a flag"); // [RULE16]

	property p_flag_clear;
		@(posedge mclk) disable iff (reset)
		(avs_write && st_r.ack && avs_address == adc_ctl_pkg::OFF_INTERRUPT_FLAGS &&
		 avs_byteenable[0])
		|=> ((st_r.flags & $past(avs_writedata[7:0] & ~event_pulse)) == 8'h00);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // [RULE16]

	property p_irq_low;
		@(posedge mclk) disable iff (reset)
		((st_r.flags & st_r.mask) == 8'h00) |=> !irq;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("irq without enabled flag"); // [RULE17]

	property p_mask_write;
		@(posedge mclk) disable iff (reset)
		(avs_write && st_r.ack && avs_address == adc_ctl_pkg::OFF_INTERRUPT_MASK && avs_byteenable[0])
		|=> (st_r.mask == ($past(avs_writedata[7:0]) & adc_ctl_pkg::IRQ_IMPL_MASK));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // [RULE1]

	property p_tconf_write;
		@(posedge mclk) disable iff (reset)
		(avs_write && st_r.ack && avs_address == adc_ctl_pkg::OFF_STARTUP_DELAY_TIMERS &&
		 avs_byteenable[2:0] == 3'h7)
		|=> (st_r.tconf == $past(avs_writedata[16:0]));
	endproperty
	a_tconf_write: assert property (p_tconf_write) else $error("timer write lost"); // [RULE9]

	property p_prech_abort;
		@(posedge mclk) disable iff (reset)
		!st_r.amp_s2 |=> ##1 !bias_precharge;
	endproperty
	a_prech_abort: assert property (p_prech_abort) else $error("precharge without enable"); // [RULE11]

	property p_conv_low;
		@(posedge mclk) disable iff (reset)
		!st_r.reg_s2 |=> !converter_on;
	endproperty
	a_conv_low: assert property (p_conv_low) else $error("converter on without regulator"); // [RULE13]

	property p_settle_start;
		@(posedge mclk) disable iff (reset)
		reg_rise |=> !converter_on;
	endproperty
	a_settle_start: assert property (p_settle_start) else $error("converter on at rise"); // [RULE13]

	property p_one_answer;
		@(posedge mclk) disable iff (reset)
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("answer held too long");

	property p_ack_req;
		@(posedge mclk) disable iff (reset)
		(!(avs_read || avs_write) && avs_waitrequest) |=> avs_waitrequest;
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("answer without request");

	property p_read_idle;
		@(posedge mclk) disable iff (reset)
		avs_waitrequest |-> (avs_readdata == 32'h0000_0000);
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside answer");

	c_irq: cover property (@(posedge mclk) disable iff (reset) $rose(irq));
	c_prech: cover property (@(posedge mclk) disable iff (reset) $fell(bias_precharge));
	c_conv: cover property (@(posedge mclk) disable iff (reset) $rose(converter_on));
	c_irq_off: cover property (@(posedge mclk) disable iff (reset) $fell(irq));
	c_conv_off: cover property (@(posedge mclk) disable iff (reset) $fell(converter_on));
endmodule : adc_irq_timers
`default_nettype wire

/* tb/adc_irq_timers_tb_top.sv */
// Self-checking bench for the converter interrupt flags, mask and start-up timers.
`timescale 1ns/10ps
`default_nettype none
module adc_irq_timers_tb_top;
	localparam int SHORT_STEP = 4;
	localparam int LONG_STEP  = SHORT_STEP * adc_ctl_pkg::LONG_STEP_MULT;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic [6:0]  avs_address = 7'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  event_pulse = 8'h00;
	logic        amplifier_enable_signal = 1'b0;
	logic        converter_regulator = 1'b0;
	logic        bias_precharge;
	logic        converter_on;
	logic        irq;
	int          error_cnt = 0;
	int          tests_run = 0;
	logic [31:0] rd;
	int          n;
	int          w;

	always #50 mclk = ~mclk;

	adc_irq_timers #(.SHORT_STEP(SHORT_STEP), .LONG_STEP(LONG_STEP)) u_adc_irq_timers (
		.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.event_pulse(event_pulse), .amplifier_enable_signal(amplifier_enable_signal),
		.converter_regulator(converter_regulator), .bias_precharge(bias_precharge),
		.converter_on(converter_on), .irq(irq));

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// The request is held until the edge that samples waitrequest low; a stuck slave ends the run.
	task automatic bus_xfer(input logic wr, input logic [6:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 50) begin
			check(32'h1, 32'h0);
			close_out();
		end
	endtask : bus_xfer

	task automatic expect_rd(input logic [6:0] a, input logic [31:0] exp);
		bus_xfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : expect_rd

	task automatic cycles(input int c);
		repeat (c) @(posedge mclk);
	endtask : cycles

	initial begin
		cycles(8);
		reset <= 1'b0;
		expect_rd(adc_ctl_pkg::OFF_INTERRUPT_MASK, 32'h0);
		expect_rd(adc_ctl_pkg::OFF_STARTUP_DELAY_TIMERS, 32'h00009628);
		expect_rd(adc_ctl_pkg::OFF_INTERRUPT_FLAGS, 32'h0);
		expect_rd(adc_ctl_pkg::OFF_VERSION_IDENT, adc_ctl_pkg::VERSION_IDENT_VALUE);
		expect_rd(7'h7c, 32'h0);
		$display("test reset_values done");

		// Each flag is raised, gated by every other mask bit, then by its own.
		for (int i = 1; i < 8; i++) begin
			@(posedge mclk);
			event_pulse <= 8'h01 << i;
			@(posedge mclk);
			event_pulse <= 8'h00;
			cycles(2);
			check({31'h0, irq}, 32'h0);
			expect_rd(adc_ctl_pkg::OFF_INTERRUPT_FLAGS, 32'h1 << i);
			bus_xfer(1'b1, adc_ctl_pkg::OFF_INTERRUPT_MASK, {24'h0, 8'hfe ^ (8'h01 << i)});
			cycles(3);
			check({31'h0, irq}, 32'h0);
			bus_xfer(1'b1, adc_ctl_pkg::OFF_INTERRUPT_MASK, 32'h1 << i);
			cycles(3);
			check({31'h0, irq}, 32'h1);
			bus_xfer(1'b1, adc_ctl_pkg::OFF_INTERRUPT_FLAGS, 32'h0);
			expect_rd(adc_ctl_pkg::OFF_INTERRUPT_FLAGS, 32'h1 << i);
			bus_xfer(1'b1, adc_ctl_pkg::OFF_INTERRUPT_FLAGS, 32'h1 << i);
			expect_rd(adc_ctl_pkg::OFF_INTERRUPT_FLAGS, 32'h0);
			cycles(2);
			check({31'h0, irq}, 32'h0);
			bus_xfer(1'b1, adc_ctl_pkg::OFF_INTERRUPT_MASK, 32'h0);
		end
		// A write with lane 0 disabled must leave the mask alone.
		avs_byteenable <= 4'he;
		bus_xfer(1'b1, adc_ctl_pkg::OFF_INTERRUPT_MASK, 32'h0000_00fe);
		avs_byteenable <= 4'hf;
		expect_rd(adc_ctl_pkg::OFF_INTERRUPT_MASK, 32'h0);
		$display("test interrupt_gating done");

		// Short step, then long step; the pulse width is counted in clock cycles.
		for (int s = 0; s < 2; s++) begin
			bus_xfer(1'b1, adc_ctl_pkg::OFF_STARTUP_DELAY_TIMERS, s ? 32'h00010105 : 32'h00000305);
			expect_rd(adc_ctl_pkg::OFF_STARTUP_DELAY_TIMERS, s ? 32'h00010105 : 32'h00000305);
			@(posedge mclk);
			amplifier_enable_signal <= 1'b1;
			n = 0;
			w = 0;
			while (bias_precharge !== 1'b1 && n < 100) begin
				@(posedge mclk);
				n++;
			end
			check({31'h0, n <= 6}, 32'h1);
			while (bias_precharge === 1'b1 && w < 5000) begin
				@(posedge mclk);
				w++;
			end
			check(w, s ? LONG_STEP : 3 * SHORT_STEP);
			amplifier_enable_signal <= 1'b0;
			cycles(4);
		end
		$display("test precharge_pulse done");

		// The regulator wait is five short steps plus the input synchroniser.
		check({31'h0, converter_on}, 32'h0);
		converter_regulator <= 1'b1;
		n = 0;
		while (converter_on !== 1'b1 && n < 200) begin
			@(posedge mclk);
			n++;
		end
		check({31'h0, n >= 5 * SHORT_STEP && n <= 5 * SHORT_STEP + 5}, 32'h1);
		converter_regulator <= 1'b0;
		cycles(6);
		check({31'h0, converter_on}, 32'h0);
		$display("test regulator_wait done");
		close_out();
	end
endmodule : adc_irq_timers_tb_top
`default_nettype wire
